/* verilog/shift4_pkg.sv */
// shared constants and types for the four-stage universal shift register
package shift4_pkg;
  localparam int STAGES = 4;
  localparam int SYNC_DEPTH = 2;
  localparam logic [3:0] STAGE_RST = 4'h0;
  localparam logic [3:0] PAR_RST = 4'h0;
  localparam logic MODE_RST = 1'b0;
  localparam logic CLEAR_N_RST = 1'b1;
  localparam logic LINE_RST = 1'b0;
  localparam logic SHIFT_CLK_RST = 1'b1;
  localparam int BUF_ENTRIES = 2;

  typedef enum logic [1:0] {
    mode_hold,
    mode_right,
    mode_left,
    mode_load
  } mode_e;
endpackage

/* verilog/word_buf2.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module word_buf2 #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  logic [WIDTH-1:0] head_ff;
  logic [WIDTH-1:0] tail_ff;
  logic head_vld_ff;
  logic tail_vld_ff;
  wire push = in_valid_i & ~tail_vld_ff;
  wire pop = head_vld_ff & out_ready_i;

  assign in_ready_o = ~tail_vld_ff;
  assign out_data_o = head_ff;
  assign out_valid_o = head_vld_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      head_ff <= '0;
      tail_ff <= '0;
      head_vld_ff <= 1'b0;
      tail_vld_ff <= 1'b0;
    end else if (pop) begin
      head_ff <= tail_vld_ff ? tail_ff : in_data_i;
      head_vld_ff <= tail_vld_ff | push;
      tail_ff <= in_data_i;
      tail_vld_ff <= tail_vld_ff & push;
    end else if (push) begin
      if (head_vld_ff) begin
        tail_ff <= in_data_i;
        tail_vld_ff <= 1'b1;
      end else begin
        head_ff <= in_data_i;
        head_vld_ff <= 1'b1;
      end
    end
  end
endmodule

/* verilog/bidir_universal_shift_reg4.sv */
// four-stage bidirectional shift register with parallel load and hold
`timescale 1ns/1ps
module bidir_universal_shift_reg4 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic shift_clk_i,
  input wire logic clear_n_i,
  input wire logic mode_select_hi_i,
  input wire logic mode_select_lo_i,
  input wire logic ser_right_i,
  input wire logic ser_left_i,
  input wire logic [3:0] par_i,
  output logic stage_out_first_o,
  output logic stage_out_second_o,
  output logic stage_out_third_o,
  output logic stage_out_fourth_o,
  output logic [3:0] word_o,
  output logic word_valid_o,
  input wire logic word_ready_i,
  output logic overrun_o
);
  localparam int PW = 10;

  function automatic shift4_pkg::mode_e decode_mode(input logic hi,
                                                    input logic lo);
    shift4_pkg::mode_e m;
    m = shift4_pkg::mode_hold;
    case ({hi, lo})
      2'b11: m = shift4_pkg::mode_load;
      2'b01: m = shift4_pkg::mode_right;
      2'b10: m = shift4_pkg::mode_left;
      2'b00: m = shift4_pkg::mode_hold;
      default: m = shift4_pkg::mode_hold;
    endcase
    return m;
  endfunction

  // pin synchroniser: clear_n, clock, hi, lo, right, left, par[3:0]
  logic [PW-1:0] pins_s1_ff;
  logic [PW-1:0] pins_s2_ff;
  logic clk_prev_ff;
  // clock pin idles high, so reset must not fake a rising edge
  localparam logic [PW-1:0] PINS_RST = {shift4_pkg::CLEAR_N_RST,
    shift4_pkg::SHIFT_CLK_RST, shift4_pkg::MODE_RST, shift4_pkg::MODE_RST,
    shift4_pkg::LINE_RST, shift4_pkg::LINE_RST, shift4_pkg::PAR_RST};

  wire [PW-1:0] pins_raw = {clear_n_i, shift_clk_i, mode_select_hi_i,
    mode_select_lo_i, ser_right_i, ser_left_i, par_i};

  wire clear_n_s = pins_s2_ff[9];
  wire clk_s = pins_s2_ff[8];
  wire [7:0] cmd_live = pins_s2_ff[7:0];

  // command: hi, lo, right, left, par
  logic pend_ff;
  logic [7:0] pend_cmd_ff;
  logic [3:0] stages_ff;
  logic overrun_ff;
  logic buf_ready;

  wire clk_rise = clk_s & ~clk_prev_ff;
  wire live_act = clk_rise & (cmd_live[7] | cmd_live[6]);
  wire [7:0] cmd = pend_ff ? pend_cmd_ff : cmd_live;
  wire want = pend_ff | live_act;
  wire go = clear_n_s & want & buf_ready;
  shift4_pkg::mode_e cmd_mode;
  assign cmd_mode = decode_mode(cmd[7], cmd[6]);
  wire cmd_ser_r = cmd[5];
  wire cmd_ser_l = cmd[4];
  wire [3:0] cmd_par = cmd[3:0];

  logic [3:0] nxt_stages;
  always_comb begin
    nxt_stages = stages_ff;
    case (cmd_mode)
      shift4_pkg::mode_load: nxt_stages = cmd_par;
      shift4_pkg::mode_right: begin
        nxt_stages = {stages_ff[2:0], cmd_ser_r};
      end
      shift4_pkg::mode_left: begin
        nxt_stages = {cmd_ser_l, stages_ff[3:1]};
      end
      shift4_pkg::mode_hold: nxt_stages = stages_ff;
      default: nxt_stages = stages_ff;
    endcase
  end

  wire nxt_pend = clear_n_s & (pend_ff ? ~go : (live_act & ~buf_ready));
  wire nxt_overrun = clear_n_s & pend_ff & live_act;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_s1_ff <= PINS_RST;
      pins_s2_ff <= PINS_RST;
      clk_prev_ff <= shift4_pkg::SHIFT_CLK_RST;
    end else begin
      pins_s1_ff <= pins_raw;
      pins_s2_ff <= pins_s1_ff;
      clk_prev_ff <= clk_s;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stages_ff <= shift4_pkg::STAGE_RST;
    end else if (!clear_n_s) begin
      stages_ff <= shift4_pkg::STAGE_RST;
    end else if (go) begin
      stages_ff <= nxt_stages;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_ff <= 1'b0;
      pend_cmd_ff <= '0;
      overrun_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      overrun_ff <= nxt_overrun;
      if (!pend_ff && live_act) begin
        pend_cmd_ff <= cmd_live;
      end
    end
  end

  word_buf2 #(
    .WIDTH(shift4_pkg::STAGES)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(nxt_stages),
    .in_valid_i(go),
    .in_ready_o(buf_ready),
    .out_data_o(word_o),
    .out_valid_o(word_valid_o),
    .out_ready_i(word_ready_i)
  );

  assign stage_out_first_o = stages_ff[0];
  assign stage_out_second_o = stages_ff[1];
  assign stage_out_third_o = stages_ff[2];
  assign stage_out_fourth_o = stages_ff[3];
  assign overrun_o = overrun_ff;
endmodule

/* dv/shift4_chk.sv */
// checker for the four-stage shift register
`timescale 1ns/1ps
module shift4_chk (
  input logic clk_i,
  input logic rst_i,
  input logic shift_clk_i,
  input logic clear_n_i,
  input logic mode_select_hi_i,
  input logic mode_select_lo_i,
  input logic ser_right_i,
  input logic ser_left_i,
  input logic [3:0] par_i,
  input logic stage_out_first_o,
  input logic stage_out_second_o,
  input logic stage_out_third_o,
  input logic stage_out_fourth_o,
  input logic [3:0] word_o,
  input logic word_valid_o,
  input logic word_ready_i
);
  wire [3:0] q = {stage_out_fourth_o, stage_out_third_o,
    stage_out_second_o, stage_out_first_o};
  wire [1:0] m = {mode_select_hi_i, mode_select_lo_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // stages moved while clear high and consumer was ready
  sequence moved;
    !$stable(q) && clear_n_i && $past(clear_n_i, 4)
      && $past(word_ready_i, 8);
  endsequence
  a_right_shift: assert property (
    moved ##0 m == 2'h1 |-> q == {$past(q[2:0]), ser_right_i})
    else $error("bad right shift");
  a_left_shift: assert property (
    moved ##0 m == 2'h2 |-> q == {ser_left_i, $past(q[3:1])})
    else $error("bad left shift");
  a_par_load: assert property (
    moved ##0 m == 2'h3 |-> q == par_i) else $error("bad load");
  a_hold_mode: assert property (
    moved |-> m != 2'h0) else $error("moved in hold");
  a_clear_zero: assert property (
    !clear_n_i [*5] |-> q == 4'h0) else $error("clear failed");
  a_edge_only: assert property (
    ($stable(shift_clk_i) && clear_n_i && word_ready_i) [*8]
    |=> $stable(q)) else $error("moved without edge");
  a_word_snap: assert property (
    $rose(word_valid_o) |-> word_o == q) else $error("bad word");
  a_word_stand: assert property (
    word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o))
    else $error("word lost");
endmodule
bind bidir_universal_shift_reg4 shift4_chk i_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .shift_clk_i(shift_clk_i),
  .clear_n_i(clear_n_i),
  .mode_select_hi_i(mode_select_hi_i),
  .mode_select_lo_i(mode_select_lo_i),
  .ser_right_i(ser_right_i),
  .ser_left_i(ser_left_i),
  .par_i(par_i),
  .stage_out_first_o(stage_out_first_o),
  .stage_out_second_o(stage_out_second_o),
  .stage_out_third_o(stage_out_third_o),
  .stage_out_fourth_o(stage_out_fourth_o),
  .word_o(word_o),
  .word_valid_o(word_valid_o),
  .word_ready_i(word_ready_i)
);

/* dv/shift4_sink.sv */
// word consumer that can stall
`timescale 1ns/1ps
module shift4_sink (
  input logic stall_i,
  output logic ready_o
);
  assign ready_o = !stall_i;
endmodule

/* dv/tb.sv */
// testbench for the four-stage shift register
`timescale 1ns/1ps
module tb;
  logic clk_i, rst_i, shift_clk_i, clear_n_i, ser_right_i, ser_left_i;
  logic mode_select_hi_i, mode_select_lo_i, word_ready_i, stall;
  logic [3:0] par_i, word_o;
  logic stage_out_first_o, stage_out_second_o, stage_out_third_o;
  logic stage_out_fourth_o, word_valid_o, overrun_o;
  int err_total = 0, checked = 0;
  int ovr_count = 0;
  wire [3:0] q = {stage_out_fourth_o, stage_out_third_o,
    stage_out_second_o, stage_out_first_o};
  bidir_universal_shift_reg4 i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .shift_clk_i(shift_clk_i),
    .clear_n_i(clear_n_i),
    .mode_select_hi_i(mode_select_hi_i),
    .mode_select_lo_i(mode_select_lo_i),
    .ser_right_i(ser_right_i),
    .ser_left_i(ser_left_i),
    .par_i(par_i),
    .stage_out_first_o(stage_out_first_o),
    .stage_out_second_o(stage_out_second_o),
    .stage_out_third_o(stage_out_third_o),
    .stage_out_fourth_o(stage_out_fourth_o),
    .word_o(word_o),
    .word_valid_o(word_valid_o),
    .word_ready_i(word_ready_i),
    .overrun_o(overrun_o)
  );
  shift4_sink i_sink (.stall_i(stall), .ready_o(word_ready_i));
  // counts dropped-edge pulses, sampled away from the launching edge
  always @(negedge clk_i) begin
    if (overrun_o === 1'b1) begin
      ovr_count++;
    end
  end
  initial begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(logic [3:0] seen, logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // selects change only while the pin clock is high
  task automatic act(logic [1:0] m, logic sr, sl, logic [3:0] p);
    {mode_select_hi_i, mode_select_lo_i} = m;
    {ser_right_i, ser_left_i, par_i} = {sr, sl, p};
    repeat (4) @(negedge clk_i);
    shift_clk_i = 0;
    repeat (4) @(negedge clk_i);
    shift_clk_i = 1;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic t_modes;
    act(2'h3, 1, 1, 4'hA);
    chk(q, 4'hA);
    act(2'h1, 1, 0, 4'h0);
    chk(q, 4'h5);
    act(2'h2, 0, 1, 4'h0);
    chk(q, 4'hA);
    act(2'h0, 1, 1, 4'hF);
    chk(q, 4'hA);
  endtask
  task automatic t_clear;
    clear_n_i = 0;
    act(2'h3, 0, 0, 4'hF);
    chk(q, 4'h0);
    clear_n_i = 1;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic t_stall;
    stall = 1;
    for (int i = 1; i < 5; i++)
      act(2'h3, 0, 0, 4'(i));
    chk(q, 4'h2);
    chk({3'h0, word_valid_o}, 4'h1);
    chk(4'(ovr_count), 4'h1);
    for (int i = 1; i < 4; i++) begin
      chk(word_o, 4'(i));
      stall = 0;
      @(negedge clk_i);
      stall = 1;
      repeat (2) @(negedge clk_i);
    end
    chk(q, 4'h3);
    chk({3'h0, word_valid_o}, 4'h0);
    stall = 0;
  endtask
  initial begin
    #100us;
    err_total++;
    wrap_up;
  end
  initial begin
    {rst_i, shift_clk_i, clear_n_i, stall} = 4'hE;
    {mode_select_hi_i, mode_select_lo_i, ser_right_i, ser_left_i} = 4'h0;
    par_i = 4'h0;
    repeat (10) @(negedge clk_i);
    rst_i = 0;
    repeat (4) @(negedge clk_i);
    t_modes;
    t_clear;
    t_stall;
    wrap_up;
  end
endmodule
